// >>> pkg/tar_pkg.sv
// Shared constants and carrier types for the per-thread architecture registers.
// Assumes one core clock; all users reach these by tar_pkg::name.
package tar_pkg;

    // ------------------------------------------------------------
    // Register type and number decode
    // ------------------------------------------------------------
    localparam logic [3:0] TYPE_ACC      = 4'h2;  // Accumulator file
    localparam logic [3:0] TYPE_FLAG     = 4'h3;  // Flag file
    localparam logic [3:0] TYPE_STATE    = 4'h7;  // Thread state register
    localparam logic [3:0] NUM_FIRST     = 4'h0;  // First register of a file
    localparam logic [3:0] NUM_SECOND    = 4'h1;  // Second register of a file
    localparam logic [4:0] SUB_FLAG_LO   = 5'h00; // Low flag half
    localparam logic [4:0] SUB_FLAG_HI   = 5'h02; // High flag half
    localparam logic [4:0] SUB_STATE_MAX = 5'h0C; // Last valid state byte

    // ------------------------------------------------------------
    // Accumulator geometry
    // ------------------------------------------------------------
    localparam int LANES      = 16;  // Word lanes per accumulator
    localparam int LANE_W     = 33;  // Bits per word lane
    localparam int SIMD_FIRST = 8;   // Float channels held by the first
    localparam int DW_CH      = 8;   // Doubleword channels, 64 bits each
    localparam int DF_CH      = 4;   // Double float channels
    localparam int W_CH       = 16;  // Word channels, 33 bits each

    // ------------------------------------------------------------
    // State register field positions and reset values
    // ------------------------------------------------------------
    localparam int SR_SLOT_LSB  = 0;   // Thread slot, 3 bits
    localparam int SR_UNIT_LSB  = 8;   // Unit index, 4 bits
    localparam int SR_HALF_SLICE_INDEX_BIT  = 12;  // Half-slice index
    localparam int SR_AGE_LSB   = 16;  // Aging priority, 3 bits
    localparam int SR_CLASS_BIT = 23;  // Priority class
    localparam int SR_FIXED_FUNCTION_SOURCE_LSB  = 24;  // Fixed-function source, 4 bits
    localparam int SR_TAG_LSB   = 24;  // Source thread tag in word one
    localparam logic [2:0] AGE_RESET = 3'h0; // Age at dispatch

    // ------------------------------------------------------------
    // Data types of the execution pipe
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DT_DF = 3'b000, DT_F  = 3'b001, DT_D  = 3'b010, DT_UD = 3'b011,
        DT_W  = 3'b100, DT_UW = 3'b101, DT_B  = 3'b110, DT_UB = 3'b111
    } tar_dtype_t;

    typedef logic [LANES-1:0][LANE_W-1:0] tar_image_t;

    // Accumulator write request
    typedef struct packed {
        logic             valid;
        logic             expl;      // Explicit destination
        logic             impl_en;   // implicit_accum_write_ctrl
        logic [3:0]       reg_num;
        tar_dtype_t       dtype;
        logic [4:0]       exec_size; // Channels, 1..16
        logic [1:0]       quarter;   // quarter_select, 0 = Q1
        logic [31:0]      word_en;   // Per word, two images
        tar_image_t [1:0] data;
    } tar_acc_wr_t;

    // Flag selection and condition write of one instruction
    typedef struct packed {
        logic        cond_valid;
        logic        is_select;  // sel opcode
        logic        flag_reg;
        logic        flag_sub;
        logic [1:0]  quarter;
        logic [2:0]  nibble;     // nibble_select
        logic        nib_mode;
        logic [4:0]  exec_size;
        logic [15:0] execution_channel_mask;      // execution_channel_mask
        logic [15:0] result;
    } tar_cond_t;

    // Explicit flag write
    typedef struct packed {
        logic        valid;
        logic [3:0]  reg_num;
        logic [4:0]  sub;
        logic        whole;
        logic [31:0] data;
    } tar_fexp_t;

    // Dispatch load
    typedef struct packed {
        logic        valid;
        logic [2:0]  slot;
        logic [3:0]  ff_source;
        logic [7:0]  ff_tag;
        logic        prio_class;
        logic [31:0] dmask;
    } tar_disp_t;

    // Explicit register read
    typedef struct packed {
        logic       valid;
        logic [3:0] reg_type;
        logic [3:0] reg_num;
        logic [4:0] sub;
        logic [3:0] chan;
    } tar_rd_t;

    // Channel offset of the selected flag slice
    function automatic logic [4:0] chan_off(input tar_cond_t c);
        chan_off = c.nib_mode ? {c.nibble, 2'b00} : {c.quarter, 3'b000};
    endfunction

endpackage

// >>> hw/tar_flag_file.sv
// Two 32-bit flag registers with condition writes and predicate reads.
// Assumes the caller supplies one flag selection per instruction.
`timescale 1ns/1ps
`default_nettype none
module tar_flag_file (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire tar_pkg::tar_cond_t cond,
    input  wire tar_pkg::tar_fexp_t fexp,
    input  wire logic [31:0]        dmask,
    output logic [1:0][31:0]        flags,
    output logic [15:0]             pred_bits,
    output logic                    branch_any
);

    // ------------------------------------------------------------
    // Slice helpers
    // ------------------------------------------------------------
    logic [4:0] off; // Channel offset of slice

    assign off = tar_pkg::chan_off(cond);

    // Bit index of a channel inside the whole register
    function automatic int bit_at(input logic sub, input logic [4:0] o, input int ch);
        bit_at = int'(sub) * 16 + int'(o) + ch;
    endfunction

    // ------------------------------------------------------------
    // Predicate read
    // ------------------------------------------------------------
    // Same register and slice as the condition write
    always_comb begin
        pred_bits = '0;
        for (int i = 0; i < 16; i++) begin
            if (bit_at(cond.flag_sub, off, i) < 32) begin
                pred_bits[i] = flags[cond.flag_reg][bit_at(cond.flag_sub, off, i)];
            end
        end
    end

    // Branch decision over every dispatch-enabled channel
    assign branch_any = |(flags[cond.flag_reg] & dmask);

    // ------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------
    // Explicit writes first, condition writes override
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= '0;
        end else begin
            // Explicit operand ignores slice fields
            if (fexp.valid && fexp.reg_num <= tar_pkg::NUM_SECOND) begin
                if (fexp.whole && fexp.sub == tar_pkg::SUB_FLAG_LO) begin
                    flags[fexp.reg_num[0]] <= fexp.data;
                end else if (fexp.sub == tar_pkg::SUB_FLAG_LO) begin
                    flags[fexp.reg_num[0]][15:0] <= fexp.data[15:0];
                end else if (fexp.sub == tar_pkg::SUB_FLAG_HI) begin
                    flags[fexp.reg_num[0]][31:16] <= fexp.data[15:0];
                end
            end
            // Select leaves flags alone
            if (cond.cond_valid && !cond.is_select) begin
                for (int i = 0; i < 16; i++) begin
                    // Enabled channels only
                    if (cond.execution_channel_mask[i] && i < int'(cond.exec_size)
                        && bit_at(cond.flag_sub, off, i) < 32) begin
                        flags[cond.flag_reg][bit_at(cond.flag_sub, off, i)] <= cond.result[i];
                    end
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> hw/tar_thread_regs.sv
// Per-thread accumulators, flags and thread state register.
// Assumes the pipe and dispatcher run on clk; reset also comes with dispatch.
`timescale 1ns/1ps
`default_nettype none
module tar_thread_regs #(
    parameter logic [3:0] UNIT_INDEX = 4'h0, // Unit of this thread
    parameter logic       HALF_SLICE = 1'b0  // Half-slice of the unit
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire tar_pkg::tar_acc_wr_t  acc_wr,
    input  wire logic                  accum_disable,
    input  wire tar_pkg::tar_cond_t    cond,
    input  wire tar_pkg::tar_fexp_t    fexp,
    input  wire tar_pkg::tar_disp_t    disp,
    input  wire logic                  thread_end,
    input  wire logic                  age_peer_valid,
    input  wire logic [2:0]            age_peer_value,
    input  wire tar_pkg::tar_rd_t      rd,
    output tar_pkg::tar_image_t        accum_first,
    output tar_pkg::tar_image_t        accum_second,
    output logic [1:0][31:0]           flags,
    output logic [15:0]                pred_bits,
    output logic                       branch_any,
    output logic                       thread_live,
    output logic [2:0]                 thread_age,
    output logic                       age_bump,
    output logic [3:0]                 sched_rank,
    output logic [3:0]                 msg_ff_source,
    output logic                       msg_prio_hint,
    output logic                       rd_valid,
    output logic                       rd_err,
    output logic [31:0]                rd_data
);

    // ------------------------------------------------------------
    // Lane helpers
    // ------------------------------------------------------------

    // Word enables widened to the lanes each type owns
    function automatic logic [15:0] lane_mask(input tar_pkg::tar_dtype_t t,
                                              input logic [15:0] we);
        lane_mask = '0;
        for (int i = 0; i < 16; i++) begin
            case (t)
                tar_pkg::DT_W, tar_pkg::DT_UW: lane_mask[i] = we[i];
                tar_pkg::DT_DF:                lane_mask[i] = we[i & ~3];
                tar_pkg::DT_B, tar_pkg::DT_UB: lane_mask[i] = 1'b0;
                default:                       lane_mask[i] = we[i & ~1];
            endcase
        end
    endfunction

    // Lane storage format per type
    function automatic logic [32:0] lane_fmt(input tar_pkg::tar_dtype_t t,
                                             input logic [32:0] v);
        case (t)
            tar_pkg::DT_W, tar_pkg::DT_UW: lane_fmt = v;
            default:                       lane_fmt = {1'b0, v[31:0]};
        endcase
    endfunction

    // ------------------------------------------------------------
    // Accumulator target decode
    // ------------------------------------------------------------
    logic                is_f;        // Single float type
    logic                is_byte;     // No accumulator for bytes
    logic                wide;        // More channels than the first holds
    logic                q_second;    // Quarter Q2 or Q4
    logic                hit_first;   // Write to first
    logic                hit_second;  // Write to second
    logic [15:0]         we_second;   // Word enables for second
    tar_pkg::tar_image_t img_second;  // Data for second
    logic [15:0]         mask_first;  // Lane enables, first
    logic [15:0]         mask_second; // Lane enables, second

    assign is_f     = acc_wr.dtype == tar_pkg::DT_F;
    assign is_byte  = acc_wr.dtype == tar_pkg::DT_B || acc_wr.dtype == tar_pkg::DT_UB;
    assign wide     = int'(acc_wr.exec_size) > tar_pkg::SIMD_FIRST;
    assign q_second = acc_wr.quarter[0];

    // Select which accumulators take this write
    always_comb begin
        hit_first  = 1'b0;
        hit_second = 1'b0;
        we_second  = acc_wr.word_en[15:0];
        img_second = acc_wr.data[0];
        if (acc_wr.valid && !is_byte) begin
            if (acc_wr.expl) begin
                // Explicit names go by register number
                hit_first  = acc_wr.reg_num == tar_pkg::NUM_FIRST;
                hit_second = acc_wr.reg_num == tar_pkg::NUM_SECOND && is_f;
            end else if (acc_wr.impl_en && !accum_disable) begin
                if (is_f && wide) begin
                    // Both halves of a wide float op
                    hit_first  = 1'b1;
                    hit_second = 1'b1;
                    we_second  = acc_wr.word_en[31:16];
                    img_second = acc_wr.data[1];
                end else if (is_f && q_second) begin
                    hit_second = 1'b1;
                end else begin
                    // Quarter falls back to the first
                    hit_first = 1'b1;
                end
            end
        end
        mask_first  = hit_first  ? lane_mask(acc_wr.dtype, acc_wr.word_en[15:0]) : '0;
        mask_second = hit_second ? lane_mask(acc_wr.dtype, we_second) : '0;
    end

    // ------------------------------------------------------------
    // Accumulator storage
    // ------------------------------------------------------------
    // First accumulator, disabled lanes keep their value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accum_first <= '0;
        end else begin
            for (int i = 0; i < tar_pkg::LANES; i++) begin
                if (mask_first[i]) begin
                    accum_first[i] <= lane_fmt(acc_wr.dtype, acc_wr.data[0][i]);
                end
            end
        end
    end

    // Second accumulator, float only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accum_second <= '0;
        end else begin
            for (int i = 0; i < tar_pkg::LANES; i++) begin
                if (mask_second[i]) begin
                    accum_second[i] <= lane_fmt(acc_wr.dtype, img_second[i]);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Flag file
    // ------------------------------------------------------------
    logic [2:0]  slot;        // thread_slot
    logic [3:0]  ff_source;   // fixed_function_source
    logic [7:0]  ff_tag;      // fixed_function_thread_tag
    logic        prio_class;  // High priority class
    logic [31:0] dmask;       // Channels enabled at dispatch
    logic [31:0] vmask;       // Group OR of dmask

    tar_flag_file u_flags (
        .clk        (clk),
        .rst_b      (rst_b),
        .cond       (cond),
        .fexp       (fexp),
        .dmask      (dmask),
        .flags      (flags),
        .pred_bits  (pred_bits),
        .branch_any (branch_any)
    );

    // ------------------------------------------------------------
    // Dispatch fields
    // ------------------------------------------------------------
    // Load identity at dispatch, fixed for the lifetime
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slot       <= '0;
            ff_source  <= '0;
            ff_tag     <= '0;
            prio_class <= 1'b0;
            dmask      <= '0;
        end else if (disp.valid) begin
            slot       <= disp.slot;
            ff_source  <= disp.ff_source;
            ff_tag     <= disp.ff_tag;
            prio_class <= disp.prio_class;
            dmask      <= disp.dmask;
        end
    end

    // Vector mask from 4-channel groups
    always_comb begin
        for (int g = 0; g < 8; g++) begin
            vmask[g*4 +: 4] = {4{|dmask[g*4 +: 4]}};
        end
    end

    // Outgoing message tags
    assign msg_ff_source = ff_source;
    assign msg_prio_hint = prio_class;

    // ------------------------------------------------------------
    // Aging priority
    // ------------------------------------------------------------
    logic [2:0] next_age; // Age after a collision

    // Bump only when a peer lands on our number
    assign age_bump = thread_live && !disp.valid && age_peer_valid
                      && age_peer_value == thread_age;
    assign next_age = thread_age + 3'h1;

    // Live flag follows dispatch and end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            thread_live <= 1'b0;
        end else if (disp.valid) begin
            thread_live <= 1'b1;
        end else if (thread_end) begin
            thread_live <= 1'b0;
        end
    end

    // Age register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            thread_age <= tar_pkg::AGE_RESET;
        end else if (disp.valid) begin
            thread_age <= tar_pkg::AGE_RESET;
        end else if (age_bump) begin
            thread_age <= next_age;
        end
    end

    // Class above any age, then larger age wins
    assign sched_rank = {prio_class, thread_age};

    // ------------------------------------------------------------
    // State register image
    // ------------------------------------------------------------
    logic [31:0]  sr_word0; // thread_state_word_zero
    logic [31:0]  sr_word1; // thread_state_word_one
    logic [127:0] sr_all;   // Four words, byte addressed

    // Assemble fields, reserved bits zero
    always_comb begin
        sr_word0 = '0;
        sr_word0[tar_pkg::SR_SLOT_LSB +: 3]  = slot;
        sr_word0[tar_pkg::SR_UNIT_LSB +: 4]  = UNIT_INDEX;
        sr_word0[tar_pkg::SR_HALF_SLICE_INDEX_BIT]       = HALF_SLICE;
        sr_word0[tar_pkg::SR_AGE_LSB +: 3]   = thread_age;
        sr_word0[tar_pkg::SR_CLASS_BIT]      = prio_class;
        sr_word0[tar_pkg::SR_FIXED_FUNCTION_SOURCE_LSB +: 4]  = ff_source;
        sr_word1 = '0;
        sr_word1[tar_pkg::SR_TAG_LSB +: 8]   = ff_tag;
    end

    assign sr_all = {vmask, dmask, sr_word1, sr_word0};

    // ------------------------------------------------------------
    // Explicit read port
    // ------------------------------------------------------------
    logic [31:0] next_rd_data; // Read mux
    logic        next_rd_err;  // Reserved encoding

    // Decode register type, number and subregister
    always_comb begin
        next_rd_data = '0;
        next_rd_err  = 1'b0;
        case (rd.reg_type)
            tar_pkg::TYPE_ACC: begin
                // Subregister must be zero
                if (rd.sub != 5'h00) begin
                    next_rd_err = 1'b1;
                end else if (rd.reg_num == tar_pkg::NUM_FIRST) begin
                    next_rd_data = accum_first[rd.chan][31:0];
                end else if (rd.reg_num == tar_pkg::NUM_SECOND) begin
                    next_rd_data = accum_second[rd.chan][31:0];
                end else begin
                    next_rd_err = 1'b1;
                end
            end
            tar_pkg::TYPE_FLAG: begin
                if (rd.reg_num > tar_pkg::NUM_SECOND) begin
                    next_rd_err = 1'b1;
                end else if (rd.sub == tar_pkg::SUB_FLAG_LO) begin
                    next_rd_data = flags[rd.reg_num[0]];
                end else if (rd.sub == tar_pkg::SUB_FLAG_HI) begin
                    next_rd_data = {16'h0000, flags[rd.reg_num[0]][31:16]};
                end else begin
                    next_rd_err = 1'b1;
                end
            end
            tar_pkg::TYPE_STATE: begin
                // Byte granular window into the four words
                if (rd.reg_num != tar_pkg::NUM_FIRST
                    || rd.sub > tar_pkg::SUB_STATE_MAX) begin
                    next_rd_err = 1'b1;
                end else begin
                    next_rd_data = 32'(sr_all >> (int'(rd.sub) * 8));
                end
            end
            default: begin
                next_rd_err = 1'b1;
            end
        endcase
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_err   <= 1'b0;
            rd_data  <= '0;
        end else begin
            rd_valid <= rd.valid;
            rd_err   <= rd.valid && next_rd_err;
            rd_data  <= rd.valid ? next_rd_data : '0;
        end
    end

endmodule
`default_nettype wire

// >>> testbench/tar_regs_sva.sv
// Port-level checker for the per-thread register block.
// Assumes one clk domain and the active-low asynchronous rst_b.
`timescale 1ns/1ps
`default_nettype none
module tar_regs_sva (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire tar_pkg::tar_acc_wr_t acc_wr,
    input wire logic                 accum_disable,
    input wire tar_pkg::tar_cond_t   cond,
    input wire tar_pkg::tar_fexp_t   fexp,
    input wire tar_pkg::tar_disp_t   disp,
    input wire tar_pkg::tar_rd_t     rd,
    input wire tar_pkg::tar_image_t  accum_first,
    input wire logic [1:0][31:0]     flags,
    input wire logic [2:0]           thread_age,
    input wire logic [3:0]           msg_ff_source,
    input wire logic                 msg_prio_hint,
    input wire logic                 rd_valid,
    input wire logic                 rd_err
);
    // ----------------------------------------
    // Timing checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Dispatch load, then zero age
    sequence s_load; disp.valid ##1 thread_age == tar_pkg::AGE_RESET; endsequence
    property p_rd_ans; rd.valid |=> rd_valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_sub_err; rd.valid && rd.reg_type == tar_pkg::TYPE_STATE
        && rd.sub > tar_pkg::SUB_STATE_MAX |=> rd_err; endproperty
    a_sub_err: assert property (p_sub_err) else $error("bad state byte taken");
    property p_acc_err; rd.valid && rd.reg_type == tar_pkg::TYPE_ACC
        && rd.reg_num > tar_pkg::NUM_SECOND |=> rd_err; endproperty
    a_acc_err: assert property (p_acc_err) else $error("bad accumulator taken");
    property p_impl; acc_wr.valid && !acc_wr.expl && (accum_disable || !acc_wr.impl_en)
        |=> $stable(accum_first); endproperty
    a_impl: assert property (p_impl) else $error("blocked implicit write landed");
    property p_byte; acc_wr.valid && acc_wr.dtype inside {tar_pkg::DT_B, tar_pkg::DT_UB}
        |=> $stable(accum_first); endproperty
    a_byte: assert property (p_byte) else $error("byte write landed");
    property p_sel; cond.cond_valid && cond.is_select && !fexp.valid |=> $stable(flags);
    endproperty
    a_sel: assert property (p_sel) else $error("select changed flags");
    property p_age; disp.valid |-> s_load; endproperty
    a_age: assert property (p_age) else $error("age not zeroed");
    property p_hint; disp.valid |=> msg_prio_hint == $past(disp.prio_class)
        && msg_ff_source == $past(disp.ff_source); endproperty
    a_hint: assert property (p_hint) else $error("message tags not loaded");
    property p_keep; !disp.valid |=> $stable(msg_prio_hint); endproperty
    a_keep: assert property (p_keep) else $error("class moved in flight");
endmodule
`default_nettype wire

// >>> testbench/tar_disp_model.sv
// Dispatcher model: turns an order into a one-cycle load pulse.
// Assumes the bench sets the order just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module tar_disp_model (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               go,
    input  wire tar_pkg::tar_disp_t order,
    output var  tar_pkg::tar_disp_t disp
);
    // One pulse per order; fields stand with the pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            disp <= '0;
        end else begin
            disp       <= order;
            disp.valid <= go;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Bench for the per-thread registers: accumulators, flags, state.
// Assumes tar_pkg, the design, the model and the checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_b, go, dis, pv, ba, rv, re;
    logic [2:0] pa, age;
    logic [3:0] sr;
    logic [31:0] rdd;
    logic [15:0] pb;
    logic [1:0][31:0] fl;
    tar_pkg::tar_acc_wr_t aw;
    tar_pkg::tar_cond_t cd;
    tar_pkg::tar_fexp_t fx;
    tar_pkg::tar_disp_t ord, dsp;
    tar_pkg::tar_rd_t rq;
    tar_pkg::tar_image_t a0, a1;
    int num_errors = 0;
    int checked = 0;
    tar_disp_model u_disp (.clk(clk), .rst_b(rst_b), .go(go), .order(ord), .disp(dsp));
    tar_thread_regs #(.UNIT_INDEX(4'hA), .HALF_SLICE(1'b1)) DUT (.clk(clk), .rst_b(rst_b),
        .acc_wr(aw), .accum_disable(dis), .cond(cd), .fexp(fx), .disp(dsp), .thread_end(1'b0),
        .age_peer_valid(pv), .age_peer_value(pa), .rd(rq), .accum_first(a0), .accum_second(a1),
        .flags(fl), .pred_bits(pb), .branch_any(ba), .thread_live(), .thread_age(age),
        .age_bump(), .sched_rank(sr), .msg_ff_source(), .msg_prio_hint(), .rd_valid(rv),
        .rd_err(re), .rd_data(rdd));
    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic step(); @(posedge clk); #1; endtask
    task automatic chk(input logic [65:0] got, input logic [65:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic rdc(input logic [3:0] t, input logic [3:0] n, input logic [4:0] s,
                       input logic e, input logic [31:0] x);
        rq = '{1'b1, t, n, s, 4'h0};
        step();
        rq.valid = 1'b0;
        chk({rv, re, rdd}, {1'b1, e, x});
        step();
    endtask
    task automatic acc(input logic ex, input logic ie, input tar_pkg::tar_dtype_t dt,
                       input logic [4:0] es, input logic [1:0] q, input logic [32:0] v);
        aw = '{1'b1, ex, ie, 4'h0, dt, es, q, ex ? 32'h0000_0001 : 32'hFFFF_FFFF,
               {{16{~v}}, {16{v}}}};
        step();
        aw.valid = 1'b0;
        step();
    endtask
    task automatic test_done();
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_b, go, dis, pv, pa} = '0;
        {aw, cd, fx, ord, rq} = '0;
        repeat (8) @(posedge clk);
        #1 rst_b = 1'b1;
        acc(0, 1, tar_pkg::DT_F, 5'd16, 2'd0, 33'h0_1111_1111);
        chk(a0[0], 33'h0_1111_1111);
        chk(a1[2], 33'h0_EEEE_EEEE);
        acc(0, 1, tar_pkg::DT_F, 5'd8, 2'd1, 33'h0_2222_2222);
        chk({a1[0], a0[0]}, {33'h0_2222_2222, 33'h0_1111_1111});
        acc(0, 1, tar_pkg::DT_B, 5'd8, 2'd0, 33'h0_3333_3333);
        dis = 1'b1;
        acc(0, 1, tar_pkg::DT_F, 5'd8, 2'd0, 33'h0_3333_3333);
        chk(a0[0], 33'h0_1111_1111);
        acc(1, 0, tar_pkg::DT_W, 5'd16, 2'd0, 33'h1_8000_0005);
        chk({a0[1], a0[0]}, {33'h0_1111_1111, 33'h1_8000_0005});
        dis = 1'b0;
        acc(0, 0, tar_pkg::DT_D, 5'd8, 2'd0, 33'h0_4444_4444);
        rdc(tar_pkg::TYPE_ACC, 4'h0, 5'h00, 1'b0, 32'h8000_0005);
        acc(0, 1, tar_pkg::DT_D, 5'd8, 2'd0, 33'h1_0000_0007);
        chk(a0[1], 33'h0_0000_0007);
        rdc(tar_pkg::TYPE_ACC, 4'h2, 5'h00, 1'b1, 32'h0);
        fx = '{1'b1, 4'h0, 5'h00, 1'b1, 32'h1234_5678};
        cd = '{1'b0, 1'b0, 1'b1, 1'b1, 2'd1, 3'd0, 1'b0, 5'd8, 16'h00FF, 16'hFFFF};
        step();
        fx.valid = 1'b0;
        cd.cond_valid = 1'b1;
        step();
        chk(fl, {32'hFF00_0000, 32'h1234_5678});
        chk(pb, 16'h00FF);
        cd = '{1'b1, 1'b1, 1'b1, 1'b1, 2'd0, 3'd0, 1'b0, 5'd16, 16'hFFFF, 16'h0000};
        step();
        cd = '0;
        chk(fl[1], 32'hFF00_0000);
        ord = '{1'b1, 3'h5, 4'h9, 8'hC3, 1'b1, 32'h0000_0080};
        go = 1'b1;
        step();
        go = 1'b0;
        step();
        chk(ba, 1'b0);
        chk(sr, 4'h8);
        rdc(tar_pkg::TYPE_STATE, 4'h0, 5'h00, 1'b0, 32'h0980_1A05);
        rdc(tar_pkg::TYPE_STATE, 4'h0, 5'h05, 1'b0, 32'h80C3_0000);
        rdc(tar_pkg::TYPE_STATE, 4'h0, 5'h0D, 1'b1, 32'h0);
        {pv, pa} = 4'b1000;
        step();
        chk(age, 3'd1);
        chk(sr, 4'h9);
        pa = 3'h3;
        step();
        pv = 1'b0;
        rdc(tar_pkg::TYPE_STATE, 4'h0, 5'h00, 1'b0, 32'h0981_1A05);
        test_done();
    end
endmodule
bind tar_thread_regs tar_regs_sva u_sva (.clk(clk), .rst_b(rst_b), .acc_wr(acc_wr),
    .accum_disable(accum_disable), .cond(cond), .fexp(fexp), .disp(disp), .rd(rd),
    .accum_first(accum_first), .flags(flags), .thread_age(thread_age),
    .msg_ff_source(msg_ff_source), .msg_prio_hint(msg_prio_hint), .rd_valid(rd_valid),
    .rd_err(rd_err));
`default_nettype wire
